/* File: rtl/wwd_params.svh */
// Constants for the window watchdog timing block
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH
`define WWD_CLK_MHZ          250
`define WWD_NC_UPPER_MS      1600
`define WWD_NC_LOWER_MS      800
`define WWD_PU_UPPER_US      11000
`define WWD_PU_LOWER_US      1850
`define WWD_CAP_SLOPE_MS_UF  77400
`define WWD_CAP_OFFSET_MS    55
`define WWD_DETECT_MAX_US    381
`define WWD_CAP_WIDTH        32
`define WWD_CNT_WIDTH        40
`endif

/* File: rtl/wwd_pkg.sv */
// Types for the window watchdog timing block
`default_nettype none
package wwd_pkg;
  typedef enum logic [1:0] {
    WWD_PIN_FLOAT,
    WWD_PIN_PULLUP,
    WWD_PIN_CAP
  } wwd_pin_mode_t;
  typedef enum logic [1:0] {
    WWD_ST_RESET,
    WWD_ST_DETECT,
    WWD_ST_RUN
  } wwd_state_t;
  typedef struct packed {
    logic vdd_above_floor;
    logic vdd_at_min;
    logic vdd_above_thresh;
  } wwd_supply_t;
endpackage
`default_nettype wire

/* File: rtl/wwd_sync2.sv */
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module wwd_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } wwd_sync_state_t;
  wwd_sync_state_t s_q;
  wwd_sync_state_t s_d;
  always_comb begin
    s_d.meta = async_i;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_o = s_q.sync;
endmodule
`default_nettype wire

/* File: rtl/wwd_window_watchdog_timing.sv */
// Window watchdog: timing pin detection, window check, output gating
// Function
// - Between power-on floor and minimum level, reset output is held low.
// - While reset is asserted, the fault output stays released.
// - In normal operation reset output follows only the undervoltage compare.
// - Floating or pulled-up pin gives factory timing, a capacitor scaled timing.
// - Floating pin uses 800 ms lower and 1600 ms upper boundaries.
// - Pulled-up pin uses 1.85 ms lower and 11.0 ms upper boundaries.
// - Capacitor mode charges the pin from a current source to a threshold.
// - Capacitor upper boundary is 77.4 s per microfarad plus 0.055 s.
// - Capacitor lower boundary is half the upper boundary.
// - With enable strap low the kick is ignored and fault is released.
// - Kicks act on falling edges and must land inside the window; the first kick after reset or strap low need only beat the upper boundary.
// - Timing pin detection reruns on each reset, within 381 us.
`include "wwd_params.svh"
`default_nettype none
module wwd_window_watchdog_timing
  import wwd_pkg::*;
#(
  parameter int unsigned CLK_MHZ = `WWD_CLK_MHZ,
  parameter logic [`WWD_CNT_WIDTH-1:0] NC_UPPER_CYC =
    `WWD_CNT_WIDTH'(64'(`WWD_NC_UPPER_MS) * 1000 * `WWD_CLK_MHZ),
  parameter logic [`WWD_CNT_WIDTH-1:0] NC_LOWER_CYC =
    `WWD_CNT_WIDTH'(64'(`WWD_NC_LOWER_MS) * 1000 * `WWD_CLK_MHZ),
  parameter logic [`WWD_CNT_WIDTH-1:0] PU_UPPER_CYC =
    `WWD_CNT_WIDTH'(64'(`WWD_PU_UPPER_US) * `WWD_CLK_MHZ),
  parameter logic [`WWD_CNT_WIDTH-1:0] PU_LOWER_CYC =
    `WWD_CNT_WIDTH'(64'(`WWD_PU_LOWER_US) * `WWD_CLK_MHZ),
  parameter logic [`WWD_CNT_WIDTH-1:0] CAP_OFFSET_CYC =
    `WWD_CNT_WIDTH'(64'(`WWD_CAP_OFFSET_MS) * 1000 * `WWD_CLK_MHZ),
  parameter logic [31:0] DETECT_MAX_CYC =
    32'(`WWD_DETECT_MAX_US * `WWD_CLK_MHZ),
  parameter logic [31:0] CAP_SCALE_NUM = 32'd1
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       vdd_above_floor_i,
  input  wire logic                       vdd_at_min_i,
  input  wire logic                       vdd_above_thresh_i,
  input  wire logic                       watchdog_kick_in_i,
  input  wire logic                       watchdog_enable_strap_i,
  input  wire logic                       window_timing_pin_i,
  input  wire logic                       pin_pullup_seen_i,
  input  wire logic                       pin_cap_seen_i,
  input  wire logic [`WWD_CAP_WIDTH-1:0]  cap_pf_i,
  output logic                            reset_n_o,
  output logic                            watchdog_fault_out_o,
  output logic                            watchdog_fault_out_oe_n_o,
  output logic                            cap_charge_en_o,
  output logic [1:0]                      pin_mode_o
);
  typedef struct packed {
    wwd_state_t                  state;
    wwd_pin_mode_t               mode;
    logic [31:0]                 det_cnt;
    logic [`WWD_CNT_WIDTH-1:0]   upper;
    logic [`WWD_CNT_WIDTH-1:0]   lower;
    logic [`WWD_CNT_WIDTH-1:0]   cnt;
    logic                        first;
    logic                        kick_prev;
    logic                        fault;
    logic                        charge;
    logic                        rst_n;
  } wwd_core_t;

  wwd_core_t  s_q;
  wwd_core_t  s_d;
  logic [6:0] pin_sync;
  wwd_supply_t sup;
  logic       kick_s;
  logic       en_s;
  logic       tpin_s;
  logic       pu_s;
  logic       cap_s;
  logic       kick_fall;
  logic [`WWD_CNT_WIDTH-1:0] cap_upper;

  wwd_sync2 #(
    .WIDTH (7)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    ({vdd_above_floor_i, vdd_at_min_i, vdd_above_thresh_i,
                  watchdog_kick_in_i, watchdog_enable_strap_i,
                  pin_pullup_seen_i, pin_cap_seen_i}),
    .sync_o     (pin_sync)
  );

  assign sup    = wwd_supply_t'(pin_sync[6:4]);
  assign kick_s = pin_sync[3];
  assign en_s   = pin_sync[2];
  assign pu_s   = pin_sync[1];
  assign cap_s  = pin_sync[0];
  assign tpin_s = window_timing_pin_i;
  // Upper boundary in cycles: (77.4 ms/nF-scale * C + 55 ms); C in pF
  assign cap_upper = `WWD_CNT_WIDTH'(
    (64'(cap_pf_i) * `WWD_CAP_SLOPE_MS_UF * CLK_MHZ / 1000
     * CAP_SCALE_NUM) + 64'(CAP_OFFSET_CYC));
  assign kick_fall = s_q.kick_prev & ~kick_s;

  always_comb begin
    s_d = s_q;
    s_d.kick_prev = kick_s;
    // Reset output tracks the supply comparator only
    s_d.rst_n = sup.vdd_above_floor & sup.vdd_at_min
              & sup.vdd_above_thresh;
    unique case (s_q.state)
      WWD_ST_RESET: begin
        s_d.fault  = 1'b0;
        s_d.charge = 1'b0;
        s_d.first  = 1'b1;
        s_d.cnt    = '0;
        if (sup.vdd_above_thresh && sup.vdd_at_min) begin
          s_d.state   = WWD_ST_DETECT;
          s_d.det_cnt = '0;
          s_d.charge  = 1'b1;
        end
      end
      WWD_ST_DETECT: begin
        s_d.det_cnt = s_q.det_cnt + 32'd1;
        if (s_q.det_cnt >= DETECT_MAX_CYC - 32'd1) begin
          s_d.charge = 1'b0;
          s_d.state  = WWD_ST_RUN;
          if (cap_s) begin
            s_d.mode  = WWD_PIN_CAP;
            s_d.upper = cap_upper;
            s_d.lower = cap_upper >> 1;
          end else if (pu_s) begin
            s_d.mode  = WWD_PIN_PULLUP;
            s_d.upper = PU_UPPER_CYC;
            s_d.lower = PU_LOWER_CYC;
          end else begin
            s_d.mode  = WWD_PIN_FLOAT;
            s_d.upper = NC_UPPER_CYC;
            s_d.lower = NC_LOWER_CYC;
          end
        end
      end
      WWD_ST_RUN: begin
        if (!en_s) begin
          s_d.fault = 1'b0;
          s_d.cnt   = '0;
          s_d.first = 1'b1;
        end else if (kick_fall) begin
          if ((!s_q.first && s_q.cnt < s_q.lower)
              || s_q.cnt >= s_q.upper) begin
            s_d.fault = 1'b1;
          end else begin
            s_d.fault = 1'b0;
          end
          s_d.cnt   = '0;
          s_d.first = 1'b0;
        end else if (s_q.cnt >= s_q.upper) begin
          s_d.fault = 1'b1;
          s_d.cnt   = '0;
        end else begin
          s_d.cnt = s_q.cnt + `WWD_CNT_WIDTH'(1);
        end
      end
      default: begin
        s_d.state = WWD_ST_RESET;
      end
    endcase
    if (!s_d.rst_n) begin
      s_d.state = WWD_ST_RESET;
      s_d.fault = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_q <= '{state: WWD_ST_RESET, mode: WWD_PIN_FLOAT, det_cnt: '0,
               upper: '0, lower: '0, cnt: '0, first: 1'b1,
               kick_prev: 1'b0, fault: 1'b0, charge: 1'b0, rst_n: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reset_n_o                 = s_q.rst_n;
  assign watchdog_fault_out_o      = 1'b0;
  assign watchdog_fault_out_oe_n_o = ~s_q.fault;
  assign cap_charge_en_o           = s_q.charge;
  assign pin_mode_o                = s_q.mode;
  logic unused_tpin;
  assign unused_tpin = tpin_s;
endmodule
`default_nettype wire

/* File: tb/wwd_props.sv */
// Checker for the window watchdog timing block
`include "wwd_params.svh"
`default_nettype none
module wwd_props #(
  parameter int unsigned DETECT_MAX = `WWD_DETECT_MAX_US * `WWD_CLK_MHZ
) (
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       vdd_above_floor_i,
  input wire logic       vdd_at_min_i,
  input wire logic       vdd_above_thresh_i,
  input wire logic       watchdog_enable_strap_i,
  input wire logic       reset_n_o,
  input wire logic       watchdog_fault_out_o,
  input wire logic       watchdog_fault_out_oe_n_o,
  input wire logic       cap_charge_en_o,
  input wire logic [1:0] pin_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Cycles spent with the charge source on
  logic [31:0] chg_cnt;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !cap_charge_en_o) begin
      chg_cnt <= 32'h0000_0000;
    end else begin
      chg_cnt <= chg_cnt + 32'h0000_0001;
    end
  end
  sequence s_supply_ok;
    (vdd_above_floor_i && vdd_at_min_i && vdd_above_thresh_i) [*5];
  endsequence
  sequence s_strap_off;
    !watchdog_enable_strap_i [*4];
  endsequence
  a_fault_in_reset: assert property (
    !reset_n_o [*2] |-> watchdog_fault_out_oe_n_o) else $error("fault in reset");
  a_supply_low: assert property (
    !vdd_at_min_i [*5] |-> !reset_n_o) else $error("reset not held");
  a_supply_ok: assert property (
    s_supply_ok |-> reset_n_o) else $error("reset not released");
  a_strap_off: assert property (
    s_strap_off |-> watchdog_fault_out_oe_n_o) else $error("fault while off");
  a_drive_low: assert property (
    watchdog_fault_out_o == 1'b0) else $error("fault data not low");
  a_detect_bound: assert property (
    cap_charge_en_o |-> chg_cnt < DETECT_MAX)
    else $error("detection too long");
  a_fault_gated: assert property (
    $fell(watchdog_fault_out_oe_n_o) |-> reset_n_o) else $error("fault gated");
  a_mode_legal: assert property (
    pin_mode_o != 2'd3) else $error("bad pin mode");
endmodule
bind wwd_window_watchdog_timing wwd_props #(.DETECT_MAX(DETECT_MAX_CYC))
  u_props (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .vdd_above_floor_i(vdd_above_floor_i), .vdd_at_min_i(vdd_at_min_i),
  .vdd_above_thresh_i(vdd_above_thresh_i),
  .watchdog_enable_strap_i(watchdog_enable_strap_i), .reset_n_o(reset_n_o),
  .watchdog_fault_out_o(watchdog_fault_out_o),
  .watchdog_fault_out_oe_n_o(watchdog_fault_out_oe_n_o),
  .cap_charge_en_o(cap_charge_en_o), .pin_mode_o(pin_mode_o));
`default_nettype wire

/* File: tb/wwd_host_model.sv */
// Host that kicks the watchdog with a falling edge every gap cycles, for a gap of 3 or more
`default_nettype none
module wwd_host_model (
  input wire logic       clk_i,
  input wire logic [7:0] gap_i,
  output var logic       kick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  initial cnt = 8'h00;
  initial kick_o = 1'b1;
  // Gap zero idles high, no edges
  always @(negedge clk_i) begin
    cnt <= (gap_i == 8'h00 || cnt >= gap_i - 8'h01) ? 8'h00 : cnt + 8'h01;
    kick_o <= (gap_i == 8'h00) || (cnt > 8'h01);
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench for the window watchdog timing block
`default_nettype none
module tb_top;
  import wwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, mn = 1, strap = 1, pu = 0, cap = 0, kick;
  logic        rn, oe_n;
  logic        fl = 1, fo, chg;
  logic [31:0] cpf = 32'd100;
  logic [1:0]  mode;
  logic [7:0]  gap = 8'h00;
  logic [31:0] seed = 32'hc07f2817;
  int          n_errors = 0, n_checks = 0, up, lo;
  always #2 clk = ~clk;
  localparam logic [39:0] NC_UP  = 40'd100;
  localparam logic [39:0] NC_LO  = 40'd50;
  localparam logic [39:0] PU_UP  = 40'd40;
  localparam logic [39:0] PU_LO  = 40'd20;
  localparam logic [39:0] CAP_OF = 40'd10;
  localparam logic [31:0] DET_MX = 32'd20;
  wwd_window_watchdog_timing #(.NC_UPPER_CYC(NC_UP), .NC_LOWER_CYC(NC_LO),
    .PU_UPPER_CYC(PU_UP), .PU_LOWER_CYC(PU_LO), .CAP_OFFSET_CYC(CAP_OF),
    .DETECT_MAX_CYC(DET_MX)) u_dut (.core_clk_i(clk), .sys_rst_i(rst),
    .vdd_above_floor_i(fl), .vdd_at_min_i(mn), .vdd_above_thresh_i(mn),
    .watchdog_kick_in_i(kick), .watchdog_enable_strap_i(strap),
    .window_timing_pin_i(pu), .pin_pullup_seen_i(pu), .pin_cap_seen_i(cap),
    .cap_pf_i(cpf), .reset_n_o(rn), .watchdog_fault_out_o(fo),
    .watchdog_fault_out_oe_n_o(oe_n), .cap_charge_en_o(chg),
    .pin_mode_o(mode));
  wwd_host_model u_host (.clk_i(clk), .gap_i(gap), .kick_o(kick));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [1:0] exp_mode(input logic p, input logic c);
    return c ? 2'd2 : (p ? 2'd1 : 2'd0);
  endfunction
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic restart;
    rst = 1;
    cyc(4);
    rst = 0;
    for (int i = 0; i < 50 && rn !== 1'b1; i++) cyc(1);
    chk({1'b0, chg}, 2'd1);
    cyc(25);
    chk({1'b0, chg}, 2'd0);
  endtask
  initial begin
    seed = xs(seed);
    cpf = 32'd100 + (seed % 32'd999901);
    for (int m = 0; m < 3; m++) begin
      pu = (m == 1);
      cap = (m == 2);
      gap <= 8'h00;
      restart;
      chk(mode, exp_mode(pu, cap));
      if (m < 2) begin
        up = m ? int'(PU_UP) : int'(NC_UP);
        lo = m ? int'(PU_LO) : int'(NC_LO);
        seed = xs(seed);
        gap <= 8'(lo + 5 + int'(seed % 32'(up - lo - 10)));
        cyc(4 * up);
        chk({1'b0, oe_n}, 2'd1);
        gap <= 8'h00;
        cyc(up + 15);
        chk({1'b0, oe_n}, 2'd0);
        strap = 0;
        cyc(6);
        chk({1'b0, oe_n}, 2'd1);
        strap = 1;
      end
      $display("mode %0d done", m);
    end
    pu = 1;
    cap = 0;
    gap <= 8'd10;
    restart;
    cyc(100);
    chk({fo, oe_n}, 2'b00);
    $display("early kick done");
    mn = 0;
    cyc(6);
    chk({rn, oe_n}, 2'b01);
    mn = 1;
    cyc(6);
    chk({rn, oe_n}, 2'b11);
    fl = 0;
    cyc(6);
    chk({rn, oe_n}, 2'b01);
    fl = 1;
    cyc(6);
    chk({rn, oe_n}, 2'b11);
    $display("supply done");
    wrap_up;
  end
  initial begin
    #60000;
    n_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
